// >>> rtl/e1fg_pkg.sv
`default_nettype none
package e1fg_pkg;
   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] MODE_CTRL_IDX    = 8'h60;
   localparam logic [7:0] MAINT_CTRL_IDX   = 8'h6c;
   localparam logic [7:0] IRQ_ENABLE_IDX   = 8'h6d;
   localparam logic [7:0] IRQ_STATUS_IDX   = 8'h6e;
   localparam logic [7:0] ERR_INSERT_IDX   = 8'h6f;
   localparam int         ADDR_W           = 12;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int FLAG_SUBMF       = 4;
   localparam int FLAG_ALIGN       = 3;
   localparam int FLAG_SIGMF       = 2;
   localparam int FLAG_CRCMF       = 1;
   localparam int FLAG_BASIC       = 0;
   localparam int INS_CRC_ALIGN    = 4;
   localparam int INS_SIG_ALIGN    = 3;
   localparam int INS_NON_ALIGN    = 2;
   localparam int INS_ALL_ALIGN    = 1;
   localparam int INS_ONE_ALIGN    = 0;
   localparam int MAINT_FORCE_ZERO = 1;
   localparam int MAINT_FORCE_ONES = 0;
   localparam int MODE_CRC_INV     = 0;
   localparam int FIELD_W          = 5;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [4:0] IRQ_ENABLE_RST = 5'h00;
   localparam logic [4:0] IRQ_STATUS_RST = 5'h00;
   localparam logic [4:0] ERR_INSERT_RST = 5'h00;
   localparam logic [1:0] MAINT_RST      = 2'h0;
   localparam logic [0:0] MODE_RST       = 1'h0;
   // ----------------------------------------------------------------
   // frame geometry
   // ----------------------------------------------------------------
   localparam logic [7:0] BITS_LAST      = 8'hff;
   localparam logic [3:0] FRAMES_LAST    = 4'hf;
   localparam logic [3:0] SUBMF_FRAME    = 4'h8;
   localparam logic [3:0] CRC_ALIGN_END  = 4'hb;
   localparam logic [7:0] TS16_FIRST     = 8'h80;
   localparam logic [7:0] TS16_ALIGN_END = 8'h83;
   localparam logic [2:0] BIT1_IDX       = 3'h0;
   localparam logic [2:0] BIT2_IDX       = 3'h1;
endpackage
`default_nettype wire

// >>> rtl/e1fg_maint.sv
// Register access over APB is this design's own decision.
`default_nettype none
module e1fg_maint (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [e1fg_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          tx_bit_valid,
   input  wire logic                          tx_bit_in,
   input  wire logic                          tx_mf_sync,
   input  wire logic                          crc_mf_mode,
   input  wire logic                          sig_mf_mode,
   output logic                               tx_bit_out,
   output logic                               tx_bit_out_valid,
   output logic                               irq_n
);
   // ----------------------------------------------------------------
   // registers and position counters
   // ----------------------------------------------------------------
   logic [4:0]  irq_enable_reg;
   logic [4:0]  irq_enable_next;
   logic [4:0]  irq_status_reg;
   logic [4:0]  irq_status_next;
   logic [4:0]  err_insert_reg;
   logic [1:0]  maint_reg;
   logic [0:0]  mode_reg;
   logic [7:0]  bit_cnt_reg;
   logic [3:0]  frame_cnt_reg;
   logic [7:0]  cur_bit;
   logic [3:0]  cur_frame;
   logic [4:0]  frame_events;
   logic        invert_bit;
   logic        ts0_bit;
   logic        even_frame;
   logic [2:0]  bit_idx;
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic        irq_n_reg;
   logic        tx_bit_out_reg;
   logic        tx_valid_reg;
   logic [7:0]  acc_idx;
   logic        acc_hit;
   logic        wr_access;
   logic        setup_phase;
   logic [4:0]  w1c_mask;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // zero-wait slave: read data is latched in setup so it leaves a flop
   assign pready      = 1'b1;
   assign prdata      = prdata_reg;
   assign pslverr     = pslverr_reg;
   assign setup_phase = psel & ~penable;
   assign wr_access   = psel & penable & pwrite & ~pslverr_reg;
   assign acc_idx     = paddr[9:2];
   assign acc_hit     = (paddr[1:0] == 2'b00) && (paddr[e1fg_pkg::ADDR_W-1:10] == 2'b00) &&
                        ((acc_idx == e1fg_pkg::MODE_CTRL_IDX) ||
                         (acc_idx == e1fg_pkg::MAINT_CTRL_IDX) ||
                         (acc_idx == e1fg_pkg::IRQ_ENABLE_IDX) ||
                         (acc_idx == e1fg_pkg::IRQ_STATUS_IDX) ||
                         (acc_idx == e1fg_pkg::ERR_INSERT_IDX));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (setup_phase) begin
         pslverr_reg <= ~acc_hit;
         prdata_reg  <= 32'h0000_0000;
         case (acc_idx)
            e1fg_pkg::MODE_CTRL_IDX:  prdata_reg <= {31'h0000_0000, mode_reg};
            e1fg_pkg::MAINT_CTRL_IDX: prdata_reg <= {30'h0000_0000, maint_reg};
            e1fg_pkg::IRQ_ENABLE_IDX: prdata_reg <= {27'h000_0000, irq_enable_reg};
            e1fg_pkg::IRQ_STATUS_IDX: prdata_reg <= {27'h000_0000, irq_status_reg};
            e1fg_pkg::ERR_INSERT_IDX: prdata_reg <= {27'h000_0000, err_insert_reg};
            default:                  prdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_enable_reg <= e1fg_pkg::IRQ_ENABLE_RST;
         err_insert_reg <= e1fg_pkg::ERR_INSERT_RST;
         maint_reg      <= e1fg_pkg::MAINT_RST;
         mode_reg       <= e1fg_pkg::MODE_RST;
      end else if (wr_access) begin
         case (acc_idx)
            e1fg_pkg::IRQ_ENABLE_IDX: irq_enable_reg <= pwdata[4:0];
            e1fg_pkg::ERR_INSERT_IDX: err_insert_reg <= pwdata[4:0];
            e1fg_pkg::MAINT_CTRL_IDX: maint_reg      <= pwdata[1:0];
            e1fg_pkg::MODE_CTRL_IDX:  mode_reg       <= pwdata[0:0];
            default:                  mode_reg       <= mode_reg;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // frame position
   // ----------------------------------------------------------------
   // a sync pulse marks bit 0 of frame 0 and overrides the free counters
   assign cur_bit   = tx_mf_sync ? 8'h00 : bit_cnt_reg;
   assign cur_frame = tx_mf_sync ? 4'h0 : frame_cnt_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_reg   <= 8'h00;
         frame_cnt_reg <= 4'h0;
      end else if (tx_bit_valid) begin
         bit_cnt_reg <= cur_bit + 8'h01;
         if (cur_bit == e1fg_pkg::BITS_LAST) begin
            frame_cnt_reg <= cur_frame + 4'h1;
         end else begin
            frame_cnt_reg <= cur_frame;
         end
      end
   end

   // ----------------------------------------------------------------
   // frame start events
   // ----------------------------------------------------------------
   always_comb begin
      frame_events = 5'h00;
      if (tx_bit_valid && (cur_bit == 8'h00)) begin
         frame_events[e1fg_pkg::FLAG_BASIC] = 1'b1;
         frame_events[e1fg_pkg::FLAG_ALIGN] = ~cur_frame[0];
         frame_events[e1fg_pkg::FLAG_CRCMF] = crc_mf_mode && (cur_frame == 4'h0);
         frame_events[e1fg_pkg::FLAG_SUBMF] = crc_mf_mode &&
            ((cur_frame == 4'h0) || (cur_frame == e1fg_pkg::SUBMF_FRAME));
         frame_events[e1fg_pkg::FLAG_SIGMF] = sig_mf_mode && (cur_frame == 4'h0);
      end
   end

   // ----------------------------------------------------------------
   // sticky status, write one to clear
   // ----------------------------------------------------------------
   // a new event in the clearing cycle wins, so no start is lost
   assign w1c_mask = (wr_access && (acc_idx == e1fg_pkg::IRQ_STATUS_IDX)) ?
                     pwdata[4:0] : 5'h00;
   assign irq_status_next = (irq_status_reg & ~w1c_mask) | frame_events;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= e1fg_pkg::IRQ_STATUS_RST;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   // enable taken from its next value so a mask write acts at the same edge as a clear
   assign irq_enable_next = (wr_access && (acc_idx == e1fg_pkg::IRQ_ENABLE_IDX)) ?
                            pwdata[4:0] : irq_enable_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_n_reg <= 1'b1;
      end else begin
         irq_n_reg <= ~|(irq_status_next & irq_enable_next);
      end
   end
   assign irq_n = irq_n_reg;

   // ----------------------------------------------------------------
   // error insertion
   // ----------------------------------------------------------------
   assign ts0_bit    = (cur_bit[7:3] == 5'h00);
   assign bit_idx    = cur_bit[2:0];
   assign even_frame = ~cur_frame[0];

   always_comb begin
      invert_bit = 1'b0;
      if (ts0_bit && even_frame) begin
         if (err_insert_reg[e1fg_pkg::INS_ALL_ALIGN] && (bit_idx != e1fg_pkg::BIT1_IDX)) begin
            invert_bit = 1'b1;
         end
         // single flip fixed on bit 2; a rotating choice buys nothing for tests
         if (err_insert_reg[e1fg_pkg::INS_ONE_ALIGN] && (bit_idx == e1fg_pkg::BIT2_IDX)) begin
            invert_bit = 1'b1;
         end
         if (mode_reg[e1fg_pkg::MODE_CRC_INV] && crc_mf_mode &&
             (bit_idx == e1fg_pkg::BIT1_IDX)) begin
            invert_bit = 1'b1;
         end
      end
      if (ts0_bit && !even_frame) begin
         if (err_insert_reg[e1fg_pkg::INS_NON_ALIGN] && (bit_idx == e1fg_pkg::BIT2_IDX)) begin
            invert_bit = 1'b1;
         end
         if (err_insert_reg[e1fg_pkg::INS_CRC_ALIGN] && crc_mf_mode &&
             (bit_idx == e1fg_pkg::BIT1_IDX) && (cur_frame <= e1fg_pkg::CRC_ALIGN_END)) begin
            invert_bit = 1'b1;
         end
      end
      if (err_insert_reg[e1fg_pkg::INS_SIG_ALIGN] && sig_mf_mode && (cur_frame == 4'h0) &&
          (cur_bit >= e1fg_pkg::TS16_FIRST) && (cur_bit <= e1fg_pkg::TS16_ALIGN_END)) begin
         invert_bit = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // output stream
   // ----------------------------------------------------------------
   // force zero outranks force ones when both are set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_bit_out_reg <= 1'b0;
         tx_valid_reg   <= 1'b0;
      end else begin
         tx_valid_reg <= tx_bit_valid;
         if (!tx_bit_valid) begin
            tx_bit_out_reg <= tx_bit_out_reg;
         end else if (maint_reg[e1fg_pkg::MAINT_FORCE_ZERO]) begin
            tx_bit_out_reg <= 1'b0;
         end else if (maint_reg[e1fg_pkg::MAINT_FORCE_ONES]) begin
            tx_bit_out_reg <= 1'b1;
         end else begin
            tx_bit_out_reg <= tx_bit_in ^ invert_bit;
         end
      end
   end
   assign tx_bit_out       = tx_bit_out_reg;
   assign tx_bit_out_valid = tx_valid_reg;
endmodule
`default_nettype wire

// >>> testbench/e1fg_maint_props.sv
`default_nettype none
module e1fg_maint_props (
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [e1fg_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0]                 pwdata,
   input wire logic                        pready,
   input wire logic                        tx_bit_valid,
   input wire logic                        tx_mf_sync,
   input wire logic                        crc_mf_mode,
   input wire logic                        sig_mf_mode,
   input wire logic                        tx_bit_out,
   input wire logic                        irq_n
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] A_EN = {2'b00, e1fg_pkg::IRQ_ENABLE_IDX, 2'b00};
   localparam logic [11:0] A_ST = {2'b00, e1fg_pkg::IRQ_STATUS_IDX, 2'b00};
   localparam logic [11:0] A_MT = {2'b00, e1fg_pkg::MAINT_CTRL_IDX, 2'b00};
   // ----
   // shadows of the bus writes
   // ----
   logic       wr;
   logic       clr_wr;
   logic       sync_ok;
   logic [4:0] en_reg;
   logic [1:0] mt_reg;
   assign wr = psel && penable && pwrite && pready;
   assign clr_wr = wr && (paddr == A_EN || paddr == A_ST);
   // a write edge is left out: the new value may land one bit later
   assign sync_ok = tx_bit_valid && tx_mf_sync && !wr;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) en_reg <= 5'h00;
      else if (wr && paddr == A_EN) en_reg <= pwdata[4:0];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) mt_reg <= 2'h0;
      else if (wr && paddr == A_MT) mt_reg <= pwdata[1:0];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_zero; tx_bit_valid && mt_reg[1] && !wr |=> !tx_bit_out; endproperty
   a_zero: assert property (p_zero) else $error("forced zero broken");
   property p_ones; tx_bit_valid && mt_reg == 2'h1 && !wr |=> tx_bit_out; endproperty
   a_ones: assert property (p_ones) else $error("forced ones broken");
   property p_basic; sync_ok && en_reg[0] |=> !irq_n; endproperty
   a_basic: assert property (p_basic) else $error("basic frame event lost");
   property p_crcmf; sync_ok && en_reg[1] && crc_mf_mode |=> !irq_n; endproperty
   a_crcmf: assert property (p_crcmf) else $error("crc multiframe event lost");
   property p_sigmf; sync_ok && en_reg[2] && sig_mf_mode |=> !irq_n; endproperty
   a_sigmf: assert property (p_sigmf) else $error("sig multiframe event lost");
   property p_submf; sync_ok && en_reg[4] && crc_mf_mode |=> !irq_n; endproperty
   a_submf: assert property (p_submf) else $error("sub multiframe event lost");
   property p_masked; en_reg == 5'h00 && $past(en_reg) == 5'h00 |-> irq_n; endproperty
   a_masked: assert property (p_masked) else $error("irq with no enable");
   property p_hold; !irq_n && !clr_wr |=> !irq_n; endproperty
   a_hold: assert property (p_hold) else $error("irq dropped with no write");
   c_event: cover property (sync_ok && en_reg != 5'h00);
   c_irq: cover property ($fell(irq_n));
   c_zero: cover property (tx_bit_valid && mt_reg[1]);
endmodule
`default_nettype wire

// >>> testbench/e1fg_stream_src.sv
`default_nettype none
module e1fg_stream_src (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        run,
   output logic             tx_bit_valid,
   output logic             tx_bit_in,
   output logic             tx_mf_sync,
   output logic [11:0]      pos
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----
   // position: frame in 11:8, bit in 7:0
   // ----
   logic data;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tx_bit_valid <= 1'b0;
      else tx_bit_valid <= run;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pos <= 12'h000;
      else if (tx_bit_valid) pos <= pos + 12'h001;
   end
   assign data = pos[0] ^ pos[3] ^ pos[9];
   // idle line shows the inverse, never a stale copy
   assign tx_bit_in = tx_bit_valid ? data : ~data;
   assign tx_mf_sync = tx_bit_valid && pos == 12'h000;
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] A_EN = {2'b00, e1fg_pkg::IRQ_ENABLE_IDX, 2'b00};
   localparam logic [11:0] A_ST = {2'b00, e1fg_pkg::IRQ_STATUS_IDX, 2'b00};
   localparam logic [11:0] A_MT = {2'b00, e1fg_pkg::MAINT_CTRL_IDX, 2'b00};
   localparam logic [11:0] A_IN = {2'b00, e1fg_pkg::ERR_INSERT_IDX, 2'b00};
   localparam logic [11:0] A_MD = {2'b00, e1fg_pkg::MODE_CTRL_IDX, 2'b00};
   logic        crc_v = 1'b0;
   logic        pclk, pready, pslverr, tx_bit_valid, tx_bit_in, tx_mf_sync, irq_n, err, d_q;
   logic        tx_bit_out, tx_bit_out_valid;
   logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
   logic        crc_mf_mode = 1'b0, sig_mf_mode = 1'b0, chk_on = 1'b0;
   logic [11:0] paddr = 12'h000, pos, pos_q;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [4:0]  ins_v = 5'h00;
   logic [1:0]  mt_v = 2'h0;
   int          bad = 0, mismatches = 0, total_checks = 0;
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   e1fg_maint e1fg_maint_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_bit_valid(tx_bit_valid), .tx_bit_in(tx_bit_in),
      .tx_mf_sync(tx_mf_sync), .crc_mf_mode(crc_mf_mode), .sig_mf_mode(sig_mf_mode),
      .tx_bit_out(tx_bit_out), .tx_bit_out_valid(tx_bit_out_valid), .irq_n(irq_n));
   e1fg_stream_src e1fg_stream_src_i (.pclk(pclk), .presetn(presetn), .run(run),
      .tx_bit_valid(tx_bit_valid), .tx_bit_in(tx_bit_in), .tx_mf_sync(tx_mf_sync), .pos(pos));
   // ----
   // expected line bit
   // ----
   function automatic logic expv(input logic d, input logic [11:0] p);
      logic inv;
      inv = (ins_v[2] && p[8] && p[7:0] == 8'h01) || (ins_v[0] && !p[8] && p[7:0] == 8'h01)
         || (ins_v[1] && !p[8] && p[7:0] >= 8'h01 && p[7:0] <= 8'h07)
         || (ins_v[4] && crc_mf_mode && p[8] && p[11:8] <= 4'hb && p[7:0] == 8'h00)
         || (ins_v[3] && sig_mf_mode && p[11:7] == 5'h01 && p[6:2] == 5'h00)
         || (crc_v && crc_mf_mode && !p[8] && p[7:0] == 8'h00);
      if (mt_v[1]) return 1'b0;
      if (mt_v[0]) return 1'b1;
      return d ^ inv;
   endfunction
   // crc bits come in from the source, so they are checked like any other bit
   always @(posedge pclk) begin
      if (tx_bit_valid) d_q <= tx_bit_in;
      if (tx_bit_valid) pos_q <= pos;
      if (chk_on && tx_bit_out_valid && tx_bit_out !== expv(d_q, pos_q)) bad <= bad + 1;
   end
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, ex, rd);
   endtask
   task automatic wpos(input logic [11:0] p);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!(tx_bit_valid && pos == p) && n < 9000);
   endtask
   task automatic t_regs();
      rdc("enable reset", A_EN, 32'h0000_0000);
      rdc("status reset", A_ST, 32'h0000_0000);
      rdc("insertion reset", A_IN, 32'h0000_0000);
      apb(1'b1, A_IN, 32'hffff_ffff);
      rdc("insertion field", A_IN, 32'h0000_001f);
      apb(1'b1, A_EN, 32'hffff_ffea);
      rdc("enable field", A_EN, 32'h0000_000a);
      apb(1'b1, A_IN, 32'h0000_0000);
      apb(1'b0, 12'h1c0, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, {31'h0, err});
      $display("test registers done");
   endtask
   task automatic t_flags();
      crc_mf_mode <= 1'b1;
      sig_mf_mode <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, A_ST, 32'h0000_001f);
         apb(1'b1, A_EN, 32'h0000_0001 << i);
         run <= 1'b1;
         wpos(12'h000);
         run <= 1'b0;
         rdc("flags at frame zero", A_ST, 32'h0000_001f);
         chk("irq enabled", 32'h0, {31'h0, irq_n});
      end
      apb(1'b1, A_ST, 32'h0000_0000);
      rdc("zero write keeps", A_ST, 32'h0000_001f);
      apb(1'b1, A_EN, 32'h0000_0000);
      @(negedge pclk);
      chk("irq masked", 32'h1, {31'h0, irq_n});
      apb(1'b1, A_ST, 32'h0000_0001);
      rdc("one clears one", A_ST, 32'h0000_001e);
      apb(1'b1, A_ST, 32'h0000_001e);
      run <= 1'b1;
      wpos(12'h800);
      run <= 1'b0;
      rdc("flags frames one to eight", A_ST, 32'h0000_0019);
      apb(1'b1, A_ST, 32'h0000_001f);
      $display("test flags done");
   endtask
   task automatic t_win(input string nm, input logic c, input logic [4:0] ins,
      input logic [1:0] mt);
      crc_mf_mode <= c;
      sig_mf_mode <= c;
      ins_v = ins;
      mt_v = mt;
      apb(1'b1, A_IN, {27'h0, ins});
      apb(1'b1, A_MT, {30'h0, mt});
      run <= 1'b1;
      wpos(12'h000);
      bad <= 0;
      chk_on <= 1'b1;
      wpos(12'h000);
      chk_on <= 1'b0;
      @(posedge pclk);
      chk(nm, 32'h0, bad);
      $display("test %s done", nm);
   endtask
   task automatic t_crc();
      crc_v = 1'b1;
      apb(1'b1, A_MD, 32'h0000_0001);
      rdc("mode field", A_MD, 32'h0000_0001);
      t_win("crc invert", 1'b1, 5'h00, 2'h0);
      crc_v = 1'b0;
      apb(1'b1, A_MD, 32'h0000_0000);
      $display("test crc invert done");
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_flags();
      t_win("pass", 1'b0, 5'h00, 2'h0);
      t_win("force zero", 1'b0, 5'h00, 2'h2);
      t_win("force ones", 1'b0, 5'h00, 2'h1);
      t_win("all and non", 1'b0, 5'h06, 2'h0);
      t_win("single", 1'b0, 5'h01, 2'h0);
      t_win("multiframe", 1'b1, 5'h18, 2'h0);
      t_crc();
      give_verdict();
   end
   initial begin
      #9_500_000;
      mismatches++;
      $display("CHECK FAILED watchdog expected end seen timeout");
      give_verdict();
   end
endmodule
bind e1fg_maint e1fg_maint_props e1fg_maint_props_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .tx_bit_valid(tx_bit_valid), .tx_mf_sync(tx_mf_sync),
   .crc_mf_mode(crc_mf_mode), .sig_mf_mode(sig_mf_mode), .tx_bit_out(tx_bit_out),
   .irq_n(irq_n));
`default_nettype wire
